// >>> hw/itpm_defines.vh
`ifndef ITPM_DEFINES_VH
`define ITPM_DEFINES_VH

// Register byte offsets
`define ITPM_CFG_OFF 12'h000
`define ITPM_MASK_OFF 12'h004
`define ITPM_SWINT_OFF 12'h008
`define ITPM_STATUS_OFF 12'h00C
`define ITPM_STYPE0_OFF 12'h010
`define ITPM_STYPE1_OFF 12'h014
`define ITPM_ICR_BASE 12'h040
`define ITPM_ADDR_W 12

// Field positions
`define ITPM_CFG_SLAVE 0
`define ITPM_CFG_CASC 1
`define ITPM_ICR_MSK 3
`define ITPM_SWINT_PEND 8

// Sizes and reset values
`define ITPM_TYPE_W 8
`define ITPM_VEC_W 20
`define ITPM_NSRC 10
`define ITPM_NLINE 12
`define ITPM_NEXT 5
`define ITPM_PR_RESET 3'h7
`define ITPM_MASK_RESET 10'h000

// Fixed type codes
`define ITPM_T_TRACE 8'h01
`define ITPM_T_NMI 8'h02
`define ITPM_T_TMR0 8'h08
`define ITPM_T_DMA0 8'h0A
`define ITPM_T_DMA1 8'h0B
`define ITPM_T_INT0 8'h0C
`define ITPM_T_WDOG 8'h11
`define ITPM_T_TMR1 8'h12
`define ITPM_T_TMR2 8'h13
`define ITPM_T_SER 8'h14

// Source indices of the lowest shared group
`define ITPM_SRC_INT4 7
`define ITPM_SRC_WDOG 8
`define ITPM_SRC_SER 9

`endif

// >>> hw/itpm_ctrl.v
// What this block does
// - Every interrupt is named by an 8-bit type code, 256 types in all.
// - Types of exceptions, peripherals and non-cascaded inputs come from this block.
// - Cascaded inputs 0-3 and, in slave mode, input 0 take their type from the external controller.
// - Vectors sit in a 1 Kbyte table from address zero, four bytes each.
// - Vector index is the type shifted left two bits.
// - Types 08h-1Fh are maskable; only 08h-14h are used, others reserved.
// - Global enable low blocks all maskable requests; high lets unmasked ones through.
// - Types 00h-07h and software interrupts ignore the global enable.
// - Each source control register holds a mask bit that blocks it when set.
// - One combined mask register shares state with the per-source mask bits.
// - Types 00h-07h always win over every maskable request.
// - Each maskable source has a 3-bit priority field, reset to level 7.
// - Software interrupts may use any of 256 types and are never masked.
// - Types 00h, 01h, 03h-07h are non-maskable execution exceptions.
// - Fixed source types per table.
// - Default order: trace, NMI, other exceptions, timers, DMA, inputs, lowest group.
// - Timers are one source with one level; timer 0 beats 1 beats 2.
// - In slave mode timer and DMA types are programmable.
// - In slave mode input 4, watchdog and serial sources are unavailable.
// - Programmable level decides first; default order breaks ties.
// - Levels run zero to seven, zero most urgent.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "itpm_defines.vh"

module itpm_ctrl #(
  parameter NSRC = `ITPM_NSRC,
  parameter NLINE = `ITPM_NLINE,
  parameter NEXT = `ITPM_NEXT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NEXT-1:0] external_request_inputs,
  input wire nmi_pin,
  input wire [7:0] exc_req,
  input wire core_if,
  input wire core_ack,
  input wire [2:0] tmr_req,
  input wire [1:0] dma_req,
  input wire wdog_req,
  input wire ser_req,
  output reg core_req,
  output reg [`ITPM_TYPE_W-1:0] core_type,
  output reg [`ITPM_VEC_W-1:0] core_vec_addr,
  output reg core_type_ext
);

  // Maps a request line to the control register that owns it
  function [3:0] line_src;
    input [3:0] line;
    begin
      if (line < 4'd3) begin
        line_src = 4'd0;
      end else begin
        line_src = line - 4'd2;
      end
    end
  endfunction

  // Fixed type code of each request line
  function [7:0] line_type;
    input [3:0] line;
    begin
      case (line)
        4'd0: line_type = `ITPM_T_TMR0;
        4'd1: line_type = `ITPM_T_TMR1;
        4'd2: line_type = `ITPM_T_TMR2;
        4'd3: line_type = `ITPM_T_DMA0;
        4'd4: line_type = `ITPM_T_DMA1;
        4'd10: line_type = `ITPM_T_WDOG;
        4'd11: line_type = `ITPM_T_SER;
        default: line_type = `ITPM_T_INT0 + {4'h0, line - 4'd5};
      endcase
    end
  endfunction

  // Pin synchronisers; first stage feeds only the second
  reg [NEXT:0] pin_meta_reg;
  reg [NEXT:0] pin_sync_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= {(NEXT+1){1'b0}};
      pin_sync_reg <= {(NEXT+1){1'b0}};
    end else begin
      pin_meta_reg <= {nmi_pin, external_request_inputs};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Configuration and mask state
  reg slave_reg;
  reg casc_reg;
  reg [NSRC-1:0] mask_reg;
  reg [2:0] pr_reg [0:NSRC-1];
  reg [31:0] stype0_reg;
  reg [7:0] stype1_reg;
  reg [7:0] sw_type_reg;
  reg sw_pend_reg;

  // APB decode: write lands at the access edge while pready is high
  wire acc = psel & penable & pready;
  wire wr_en = acc & pwrite;
  wire [`ITPM_ADDR_W-1:0] addr = paddr[`ITPM_ADDR_W-1:0];
  wire icr_hit = (addr >= `ITPM_ICR_BASE) &&
    (addr < `ITPM_ICR_BASE + 12'd4 * NSRC[11:0]) && (addr[1:0] == 2'b00);
  wire [3:0] icr_idx = addr[5:2];
  wire hit = icr_hit || addr == `ITPM_CFG_OFF || addr == `ITPM_MASK_OFF ||
    addr == `ITPM_SWINT_OFF || addr == `ITPM_STATUS_OFF ||
    addr == `ITPM_STYPE0_OFF || addr == `ITPM_STYPE1_OFF;

  // Arbitration result
  reg win_valid;
  reg [7:0] win_type;
  reg win_ext;
  reg win_is_sw;
  reg [NLINE-1:0] line_pend;
  reg [2:0] best_pr;
  reg found;
  reg [7:0] t;
  reg [3:0] s;
  integer i;

  // Raw request lines in default overall order
  always @* begin
    line_pend = {ser_req, wdog_req, pin_sync_reg[NEXT-1:0], dma_req, tmr_req};
    if (slave_reg) begin
      line_pend[11:9] = 3'b000;
    end
  end

  // Priority pick, one winner only
  always @* begin
    win_valid = 1'b0;
    win_type = 8'h00;
    win_ext = 1'b0;
    win_is_sw = 1'b0;
    best_pr = 3'h7;
    found = 1'b0;
    t = 8'h00;
    s = 4'h0;
    if (exc_req[1]) begin
      win_valid = 1'b1;
      win_type = `ITPM_T_TRACE;
    end else if (pin_sync_reg[NEXT]) begin
      win_valid = 1'b1;
      win_type = `ITPM_T_NMI;
    end else if (exc_req != 8'h00) begin
      // Remaining exceptions are mutually exclusive, lowest index taken
      win_valid = 1'b1;
      for (i = 7; i >= 0; i = i - 1) begin
        if (exc_req[i] && i != 2) begin
          win_type = i[7:0];
        end
      end
    end else if (sw_pend_reg) begin
      win_valid = 1'b1;
      win_type = sw_type_reg;
      win_is_sw = 1'b1;
    end else if (core_if) begin
      // Strict less-than keeps the earlier line on equal levels
      for (i = 0; i < NLINE; i = i + 1) begin
        s = line_src(i[3:0]);
        if (line_pend[i] && !mask_reg[s] &&
            (!found || pr_reg[s] < best_pr)) begin
          found = 1'b1;
          best_pr = pr_reg[s];
          t = line_type(i[3:0]);
          if (slave_reg && i < 4) begin
            t = stype0_reg[8*i +: 8];
          end else if (slave_reg && i == 4) begin
            t = stype1_reg;
          end
          win_type = t;
          // Master controller or cascaded part supplies the type
          win_ext = (slave_reg && i == 5) ||
            (casc_reg && !slave_reg && i >= 5 && i <= 8);
        end
      end
      win_valid = found;
    end
  end

  // Core-facing outputs, registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req <= 1'b0;
      core_type <= 8'h00;
      core_vec_addr <= 20'h0_0000;
      core_type_ext <= 1'b0;
    end else begin
      core_req <= win_valid;
      core_type <= win_type;
      core_vec_addr <= {10'h000, win_type, 2'b00};
      core_type_ext <= win_ext;
    end
  end

  // Software interrupt pending flag; a new write beats the ack
  wire sw_wr = wr_en && addr == `ITPM_SWINT_OFF;
  wire sw_taken = core_ack && core_req && win_is_sw;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_pend_reg <= 1'b0;
      sw_type_reg <= 8'h00;
    end else begin
      if (sw_wr) begin
        sw_pend_reg <= 1'b1;
        sw_type_reg <= pwdata[7:0];
      end else if (sw_taken) begin
        sw_pend_reg <= 1'b0;
      end
    end
  end

  // Configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_reg <= 1'b0;
      casc_reg <= 1'b0;
      stype0_reg <= 32'h0000_0000;
      stype1_reg <= 8'h00;
    end else if (wr_en) begin
      if (addr == `ITPM_CFG_OFF) begin
        slave_reg <= pwdata[`ITPM_CFG_SLAVE];
        casc_reg <= pwdata[`ITPM_CFG_CASC];
      end
      if (addr == `ITPM_STYPE0_OFF) begin
        stype0_reg <= pwdata;
      end
      if (addr == `ITPM_STYPE1_OFF) begin
        stype1_reg <= pwdata[7:0];
      end
    end
  end

  // Mask bits: both views write the same flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `ITPM_MASK_RESET;
    end else if (wr_en && addr == `ITPM_MASK_OFF) begin
      mask_reg <= pwdata[NSRC-1:0];
    end else if (wr_en && icr_hit) begin
      mask_reg[icr_idx] <= pwdata[`ITPM_ICR_MSK];
    end
  end

  // Priority fields, one per source
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_pr
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pr_reg[g] <= `ITPM_PR_RESET;
        end else if (wr_en && icr_hit && icr_idx == g) begin
          pr_reg[g] <= pwdata[2:0];
        end
      end
    end
  endgenerate

  // Read mux
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0000_0000;
    if (icr_hit) begin
      rd_next = {28'h000_0000, mask_reg[icr_idx], pr_reg[icr_idx]};
    end else begin
      case (addr)
        `ITPM_CFG_OFF: rd_next = {30'h0000_0000, casc_reg, slave_reg};
        `ITPM_MASK_OFF: rd_next = {22'h00_0000, mask_reg};
        `ITPM_SWINT_OFF: rd_next = {23'h00_0000, sw_pend_reg, sw_type_reg};
        `ITPM_STATUS_OFF: rd_next = {10'h000, line_pend, core_type_ext, core_req, core_type};
        `ITPM_STYPE0_OFF: rd_next = stype0_reg;
        `ITPM_STYPE1_OFF: rd_next = {24'h00_0000, stype1_reg};
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  // APB answer: ready in the first access cycle, data and error with it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata <= (psel & ~penable & ~pwrite & hit) ? rd_next : 32'h0000_0000;
    end
  end

endmodule // itpm_ctrl

// >>> bench/itpm_core_model.sv
`timescale 1ns/1ps
module itpm_core_model (
  input wire pclk,
  input wire presetn,
  input wire if_en,
  input wire ack_en,
  input wire core_req,
  output reg core_if,
  output reg core_ack
);
  // Core flag and one-cycle acknowledge of a presented request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_if <= 1'b0;
      core_ack <= 1'b0;
    end else begin
      core_if <= if_en;
      core_ack <= ack_en & core_req & ~core_ack;
    end
  end
endmodule // itpm_core_model

// >>> bench/itpm_chk.sv
`timescale 1ns/1ps
module itpm_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] exc_req,
  input wire core_if,
  input wire [2:0] tmr_req,
  input wire [1:0] dma_req,
  input wire core_req,
  input wire [7:0] core_type,
  input wire [19:0] core_vec_addr,
  input wire core_type_ext
);
  // Presented request is one of the used maskable types
  wire mtyp = core_req && !core_type_ext && core_type >= 8'h08 && core_type <= 8'h14;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable;
  endsequence
  apb_answer_a:
    assert property (apb_setup |=> pready ##1 !pready) else $error("late apb answer");
  rd_idle_a:
    assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr) else $error("idle rdata");
  vec_index_a:
    assert property (core_req && !core_type_ext |-> core_vec_addr == {10'h000, core_type, 2'b00})
      else $error("vector index");
  if_gate_a:
    assert property (mtyp |-> $past(core_if)) else $error("flag ignored");
  exc_first_a:
    assert property (mtyp |-> ($past(exc_req) & 8'hFB) == 8'h00) else $error("exception lost");
  trace_top_a:
    assert property ($past(exc_req[1]) |-> core_req && core_type == 8'h01) else $error("trace");
  dma_type_a:
    assert property (core_req && core_type == 8'h0A |-> $past(dma_req[0])) else $error("dma type");
  tmr_order_a:
    assert property (core_req && core_type == 8'h12 |-> $past(tmr_req[1]) && !$past(tmr_req[0]))
      else $error("timer order");
endmodule // itpm_chk

bind itpm_ctrl itpm_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .exc_req(exc_req), .core_if(core_if),
  .tmr_req(tmr_req), .dma_req(dma_req), .core_req(core_req), .core_type(core_type),
  .core_vec_addr(core_vec_addr), .core_type_ext(core_type_ext));

// >>> bench/interrupt_type_priority_mask_tb.sv
`timescale 1ns/1ps
module interrupt_type_priority_mask_tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi_pin = 0;
  reg wdog_req = 0, ser_req = 0, if_en = 0, ack_en = 0, serr;
  reg [31:0] paddr = 0, pwdata = 0, rd;
  reg [4:0] ext_in = 0;
  reg [7:0] exc_req = 0;
  reg [2:0] tmr_req = 0;
  reg [1:0] dma_req = 0;
  wire [31:0] prdata;
  wire pready, pslverr, core_if, core_ack, core_req, core_type_ext;
  wire [7:0] core_type;
  wire [19:0] core_vec_addr;
  integer err_count = 0, n_compared = 0, cycles = 0, i;
  always #5 pclk = ~pclk;
  itpm_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_request_inputs(ext_in), .nmi_pin(nmi_pin),
    .exc_req(exc_req), .core_if(core_if), .core_ack(core_ack), .tmr_req(tmr_req),
    .dma_req(dma_req), .wdog_req(wdog_req), .ser_req(ser_req), .core_req(core_req),
    .core_type(core_type), .core_vec_addr(core_vec_addr), .core_type_ext(core_type_ext));
  itpm_core_model core (.pclk(pclk), .presetn(presetn), .if_en(if_en), .ack_en(ack_en),
    .core_req(core_req), .core_if(core_if), .core_ack(core_ack));
  task stop_test;
    begin
      if (err_count == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer, held until pready is seen
  task apb(input w, input [31:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      serr = pslverr;
      psel <= 0; penable <= 0;
    end
  endtask
  // Request settles within the sync plus register delay
  task core_chk(input [7:0] t);
    begin
      repeat (4) @(posedge pclk);
      chk({core_req, core_type_ext, core_type}, {2'b10, t});
      chk(core_vec_addr, {t, 2'b00});
    end
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 10; i = i + 1) begin
      apb(0, 32'h0000_0040 + 4 * i, 0);
      chk(rd, 32'h0000_0007);
    end
    apb(0, 32'h0000_0030, 0);
    chk(serr, 1);
    apb(1, 32'h0000_0004, 32'h0000_0002);
    apb(0, 32'h0000_0044, 0);
    chk(rd, 32'h0000_000F);
    apb(1, 32'h0000_0044, 32'h0000_0007);
    apb(0, 32'h0000_0004, 0);
    chk(rd, 0);
    dma_req <= 2'b11;
    if_en <= 1;
    core_chk(8'h0A);
    apb(1, 32'h0000_0048, 32'h0000_0006);
    core_chk(8'h0B);
    apb(1, 32'h0000_0048, 32'h0000_000E);
    core_chk(8'h0A);
    if_en <= 0;
    repeat (4) @(posedge pclk);
    chk(core_req, 0);
    exc_req <= 8'h03;
    core_chk(8'h01);
    exc_req <= 8'h01;
    core_chk(8'h00);
    exc_req <= 0; if_en <= 1; dma_req <= 0; tmr_req <= 3'b110;
    core_chk(8'h12);
    tmr_req <= 0; wdog_req <= 1; ser_req <= 1;
    core_chk(8'h11);
    wdog_req <= 0; ser_req <= 0; ext_in <= 5'b00001;
    core_chk(8'h0C);
    apb(1, 32'h0000_0000, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk({core_req, core_type_ext}, 2'b11);
    ext_in <= 0;
    apb(1, 32'h0000_0000, 32'h0000_0001);
    apb(1, 32'h0000_0010, 32'h0000_0040);
    tmr_req <= 3'b001;
    core_chk(8'h40);
    tmr_req <= 0; wdog_req <= 1;
    repeat (4) @(posedge pclk);
    chk(core_req, 0);
    wdog_req <= 0;
    apb(1, 32'h0000_0000, 32'h0000_0000);
    apb(1, 32'h0000_0008, 32'h0000_00FF);
    core_chk(8'hFF);
    ack_en <= 1;
    repeat (4) @(posedge pclk);
    apb(0, 32'h0000_0008, 0);
    chk(rd[8], 0);
    chk(core_req, 0);
    stop_test;
  end
endmodule // interrupt_type_priority_mask_tb
